// File: hdl/cpu_clock_wait_bus_control.sv
`timescale 1ns/1ns
// How it works
// - Fast mode divides oscillator by four, 4 MHz.
// - Force-low loads preset 1,0,0, divide by nine.
// - Fast mode loads preset 0,1,1.
// - At 4 MHz ROM reads assert wait.
// - Auto mode floppy access fires slowdown one-shot.
// - Return to fast speed only at cycle boundary.
// - Upper address held in transparent latch.
// - Refresh puts refresh address on low bits.
// - Data direction high drives toward processor.
// - One ROM wait, one or two video waits.
// - Program RAM accesses get no wait.
// - Expansion wait ORed into processor wait.
// - Interrupt passed to processor, vector 0038H.
// - Bus request tri-states address, data, control.
// - Read plus memory request gives read strobes.
// - Write plus memory request gives write strobes.
// - Graphics enable adds external read/write strobes in lower 16K.
// - I/O request decoded into output/input strobes.
// - Refresh clears the address-multiplex flip-flop.
// - 3-to-8 decode from A15, request, A12-A14.
module cpu_clock_wait_bus_control #(
	parameter int ONESHOT_LEN = cpu_glue_pkg::ONESHOT_CYCLES
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Speed control.
	input wire logic speed_select_switch_i,
	input wire logic auto_speed_switch_i,
	output logic cpu_clk_o,
	output logic cpu_clk_rise_o,
	output logic high_speed_active_n_o,
	output logic force_low_speed_n_o,
	// Processor side.
	input wire logic [15:0] cpu_addr_i,
	input wire cpu_glue_pkg::cpu_ctl_t cpu_ctl_i,
	input wire logic [7:0] cpu_data_i,
	output logic [7:0] cpu_data_o,
	output logic cpu_wait_n_o,
	output logic cpu_int_n_o,
	output logic cpu_busrq_n_o,
	// System side.
	input wire logic [7:0] sys_data_i,
	output logic [15:0] sys_addr_o,
	output logic [7:0] sys_data_o,
	output logic sys_addr_oe_n_o,
	output logic sys_data_oe_n_o,
	output logic sys_ctl_oe_n_o,
	output logic data_in_direction_o,
	output cpu_glue_pkg::sys_strobe_t strobes_o,
	output logic buffered_mem_request_n_o,
	output logic addr_mux_o,
	output logic column_strobe_n_o,
	output logic [7:0] region_select_n_o,
	output logic rom_read_n_o,
	// Configuration and expansion bus.
	input wire logic graphics_enable_i,
	input wire logic ext_wait_n_i,
	input wire logic ext_int_n_i,
	input wire logic ext_busrq_n_i
);

	////////////////////////////////////////////////////////////////////////////
	logic [3:0] div_r;
	logic [15:0] oneshot_r;
	logic slow_r;
	logic cpu_clk_r;
	logic fire;
	logic slow_req;
	logic div_wrap;

	// A manual slow request or a running one-shot selects the slow preset.
	assign fire = auto_speed_switch_i && !cpu_ctl_i.mreq_n && cpu_addr_i == cpu_glue_pkg::FLOPPY_ADDR;
	assign slow_req = !speed_select_switch_i || (oneshot_r != 16'h0000);
	assign force_low_speed_n_o = !slow_r;
	assign high_speed_active_n_o = slow_r;
	assign div_wrap = (div_r == (slow_r ? cpu_glue_pkg::DIV_LAST_LOW : cpu_glue_pkg::DIV_LAST_HIGH));

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			oneshot_r <= 16'h0000;
		end else if (fire) begin
			oneshot_r <= 16'(ONESHOT_LEN);
		end else if (oneshot_r != 16'h0000) begin
			oneshot_r <= oneshot_r - 16'h0001;
		end
	end

	// Speed only changes when the counter reloads, so no clock phase is cut short.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			slow_r <= 1'b0;
			div_r <= cpu_glue_pkg::PRESET_HIGH;
		end else if (div_wrap) begin
			slow_r <= slow_req;
			div_r <= slow_req ? cpu_glue_pkg::PRESET_LOW : cpu_glue_pkg::PRESET_HIGH;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	// The system clock stands in for the 16 MHz oscillator but runs here at CLK_HZ, 10 MHz.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cpu_clk_r <= 1'b0;
		end else if (div_wrap) begin
			cpu_clk_r <= 1'b1;
		end else if (div_r == (slow_r ? cpu_glue_pkg::HALF_LOW : cpu_glue_pkg::HALF_HIGH)) begin
			cpu_clk_r <= 1'b0;
		end
	end
	assign cpu_clk_o = cpu_clk_r;
	assign cpu_clk_rise_o = div_wrap;

	////////////////////////////////////////////////////////////////////////////
	logic bus_given;
	logic [7:0] upper_r;
	logic in_lower16k;
	logic rom_sel;
	logic video_sel;
	logic [1:0] wait_cnt_r;
	logic wait_extend_hold;
	logic cycle_active_r;
	logic mem_cycle;

	assign bus_given = !ext_busrq_n_i;
	assign cpu_busrq_n_o = ext_busrq_n_i;
	assign sys_addr_oe_n_o = bus_given;
	assign sys_data_oe_n_o = bus_given;
	assign sys_ctl_oe_n_o = bus_given;
	assign cpu_int_n_o = ext_int_n_i;

	// Upper address is transparent while neither a memory request nor an I/O request holds it.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			upper_r <= 8'h00;
		end else if (cpu_ctl_i.mreq_n && cpu_ctl_i.iorq_n) begin
			upper_r <= cpu_addr_i[15:8];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sys_addr_o <= 16'h0000;
		end else begin
			sys_addr_o[15:8] <= (cpu_ctl_i.mreq_n && cpu_ctl_i.iorq_n) ? cpu_addr_i[15:8] : upper_r;
			sys_addr_o[7:0] <= cpu_addr_i[7:0];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sys_data_o <= 8'h00;
			cpu_data_o <= 8'h00;
		end else begin
			sys_data_o <= cpu_data_i;
			cpu_data_o <= sys_data_i;
		end
	end
	assign data_in_direction_o = !cpu_ctl_i.rd_n;

	assign in_lower16k = cpu_addr_i <= cpu_glue_pkg::LOWER_16K_TOP;
	assign rom_sel = cpu_addr_i <= cpu_glue_pkg::ROM_TOP;
	assign video_sel = in_lower16k && cpu_addr_i >= cpu_glue_pkg::VIDEO_BASE;
	assign mem_cycle = !cpu_ctl_i.mreq_n && cpu_ctl_i.refresh_cycle_n_n && bus_given == 1'b0;
	assign rom_read_n_o = !(mem_cycle && !cpu_ctl_i.rd_n && rom_sel);
	assign buffered_mem_request_n_o = cpu_ctl_i.mreq_n;

	// Waits are counted in processor clocks; program RAM never starts a count.
	assign wait_extend_hold = video_sel && !cpu_ctl_i.rd_n;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_cnt_r <= 2'h0;
			cycle_active_r <= 1'b0;
		end else if (!mem_cycle || (cpu_ctl_i.rd_n && cpu_ctl_i.wr_n)) begin
			wait_cnt_r <= 2'h0;
			cycle_active_r <= 1'b0;
		end else if (!cycle_active_r) begin
			cycle_active_r <= 1'b1;
			if (!slow_r && !rom_read_n_o) begin
				wait_cnt_r <= cpu_glue_pkg::ROM_WAITS;
			end else if (!slow_r && video_sel) begin
				wait_cnt_r <= wait_extend_hold ? cpu_glue_pkg::VIDEO_READ_WAITS
					: cpu_glue_pkg::VIDEO_WRITE_WAITS;
			end else begin
				wait_cnt_r <= 2'h0;
			end
		end else if (div_wrap && wait_cnt_r != 2'h0) begin
			wait_cnt_r <= wait_cnt_r - 2'h1;
		end
	end
	assign cpu_wait_n_o = (wait_cnt_r == 2'h0) && ext_wait_n_i;

	////////////////////////////////////////////////////////////////////////////
	logic lower_mem_disable;
	logic mux_r;
	cpu_glue_pkg::sys_strobe_t strb;

	assign lower_mem_disable = graphics_enable_i && in_lower16k;
	always_comb begin
		strb.internal_mem_read_n = !(mem_cycle && !cpu_ctl_i.rd_n);
		strb.external_read_out_n = !(mem_cycle && !cpu_ctl_i.rd_n && lower_mem_disable);
		strb.internal_mem_write_n = !(mem_cycle && !cpu_ctl_i.wr_n);
		strb.external_write_out_n = !(mem_cycle && !cpu_ctl_i.wr_n && lower_mem_disable);
		strb.io_output_strobe_n = !(!bus_given && !cpu_ctl_i.iorq_n && !cpu_ctl_i.wr_n);
		strb.io_input_strobe_n = !(!bus_given && !cpu_ctl_i.iorq_n && !cpu_ctl_i.rd_n);
	end
	assign strobes_o = strb;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mux_r <= 1'b0;
		end else if (!cpu_ctl_i.refresh_cycle_n_n) begin
			mux_r <= 1'b0;
		end else begin
			mux_r <= !cpu_ctl_i.mreq_n;
		end
	end
	assign addr_mux_o = mux_r;
	assign column_strobe_n_o = !(mux_r && cpu_ctl_i.refresh_cycle_n_n);

	// The decoder is enabled only by a low A15 and an active memory request.
	always_comb begin
		region_select_n_o = 8'hFF;
		if (!cpu_addr_i[15] && !cpu_ctl_i.mreq_n) begin
			region_select_n_o[cpu_addr_i[14:12]] = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	property p_fast_wrap;
		@(posedge clk_i) disable iff (rst_i) (div_wrap && !slow_req) |-> ##4 div_wrap;
	endproperty
	a_fast_wrap: assert property (p_fast_wrap) else $error("fast divider not four");
	property p_slow_nine;
		@(posedge clk_i) disable iff (rst_i) (div_wrap && slow_req) |=> !div_wrap [*8] ##1 div_wrap;
	endproperty
	a_slow_nine: assert property (p_slow_nine) else $error("slow divider not nine");
	property p_rom_wait;
		@(posedge clk_i) disable iff (rst_i)
			$rose(cycle_active_r) && !$past(slow_r) && !$past(rom_read_n_o) && ext_wait_n_i
			|-> !cpu_wait_n_o;
	endproperty
	a_rom_wait: assert property (p_rom_wait) else $error("rom wait missing");
	property p_oneshot;
		@(posedge clk_i) disable iff (rst_i) fire |=> oneshot_r == 16'(ONESHOT_LEN);
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot not loaded");
	property p_speed_sync;
		@(posedge clk_i) disable iff (rst_i) !div_wrap |=> $stable(slow_r);
	endproperty
	a_speed_sync: assert property (p_speed_sync) else $error("speed changed mid cycle");
	property p_ext_wait;
		@(posedge clk_i) disable iff (rst_i) !ext_wait_n_i |-> !cpu_wait_n_o;
	endproperty
	a_ext_wait: assert property (p_ext_wait) else $error("external wait lost");
	property p_busrq;
		@(posedge clk_i) disable iff (rst_i)
			!ext_busrq_n_i |-> sys_addr_oe_n_o && sys_data_oe_n_o && strobes_o.internal_mem_read_n;
	endproperty
	a_busrq: assert property (p_busrq) else $error("buffers not released");
	property p_ext_read;
		@(posedge clk_i) disable iff (rst_i)
			!strobes_o.external_read_out_n |-> !strobes_o.internal_mem_read_n && graphics_enable_i;
	endproperty
	a_ext_read: assert property (p_ext_read) else $error("bad external read");
	property p_refresh_mux;
		@(posedge clk_i) disable iff (rst_i) !cpu_ctl_i.refresh_cycle_n_n |=> !addr_mux_o;
	endproperty
	a_refresh_mux: assert property (p_refresh_mux) else $error("mux not cleared");
	c_slow: cover property (@(posedge clk_i) disable iff (rst_i) fire ##1 slow_r [*3]);
	c_rom: cover property (@(posedge clk_i) disable iff (rst_i) !cpu_wait_n_o && !rom_read_n_o);
	c_bus: cover property (@(posedge clk_i) disable iff (rst_i) !ext_busrq_n_i);
	c_video: cover property (@(posedge clk_i) disable iff (rst_i) !cpu_wait_n_o && wait_extend_hold);
	c_refresh: cover property (@(posedge clk_i) disable iff (rst_i)
		!cpu_ctl_i.refresh_cycle_n_n && !addr_mux_o);

	////////////////////////////////////////////////////////////////////////////
	// The wait checks look one cycle back, since the count loads from the previous inputs.
	property p_fast_preset;
		@(posedge clk_i) disable iff (rst_i)
			(div_wrap && !slow_req) |=> div_r == cpu_glue_pkg::PRESET_HIGH;
	endproperty
	a_fast_preset: assert property (p_fast_preset) else $error("fast preset wrong");
	property p_slow_preset;
		@(posedge clk_i) disable iff (rst_i)
			(div_wrap && slow_req) |=> div_r == cpu_glue_pkg::PRESET_LOW;
	endproperty
	a_slow_preset: assert property (p_slow_preset) else $error("slow preset wrong");
	property p_oneshot_slow;
		@(posedge clk_i) disable iff (rst_i) (oneshot_r != 16'h0000 && div_wrap) |=> slow_r;
	endproperty
	a_oneshot_slow: assert property (p_oneshot_slow) else $error("one-shot not slowing");
	property p_auto_return;
		@(posedge clk_i) disable iff (rst_i)
			(speed_select_switch_i && oneshot_r == 16'h0000 && div_wrap) |=> !slow_r;
	endproperty
	a_auto_return: assert property (p_auto_return) else $error("fast speed not restored");
	property p_upper_hold;
		@(posedge clk_i) disable iff (rst_i)
			!cpu_ctl_i.mreq_n |=> sys_addr_o[15:8] == $past(upper_r);
	endproperty
	a_upper_hold: assert property (p_upper_hold) else $error("upper address moved");
	property p_refresh_addr;
		@(posedge clk_i) disable iff (rst_i)
			!cpu_ctl_i.refresh_cycle_n_n |=> {9'h000, sys_addr_o[6:0]} == ($past(cpu_addr_i) & 16'h007F);
	endproperty
	a_refresh_addr: assert property (p_refresh_addr) else $error("refresh address lost");
	property p_data_dir;
		@(posedge clk_i) disable iff (rst_i) data_in_direction_o == !cpu_ctl_i.rd_n;
	endproperty
	a_data_dir: assert property (p_data_dir) else $error("data direction wrong");
	property p_video_read_wait;
		@(posedge clk_i) disable iff (rst_i)
			$rose(cycle_active_r) && !$past(slow_r) && $past(wait_extend_hold)
			|-> wait_cnt_r == cpu_glue_pkg::VIDEO_READ_WAITS;
	endproperty
	a_video_read_wait: assert property (p_video_read_wait) else $error("video wait wrong");
	property p_ram_nowait;
		@(posedge clk_i) disable iff (rst_i)
			$rose(cycle_active_r) && !$past(video_sel) && $past(rom_read_n_o)
			|-> wait_cnt_r == 2'h0;
	endproperty
	a_ram_nowait: assert property (p_ram_nowait) else $error("program memory waited");
	property p_int_pass;
		@(posedge clk_i) disable iff (rst_i) cpu_int_n_o == ext_int_n_i;
	endproperty
	a_int_pass: assert property (p_int_pass) else $error("interrupt not passed");
	property p_ext_write;
		@(posedge clk_i) disable iff (rst_i)
			!strobes_o.external_write_out_n |-> !strobes_o.internal_mem_write_n && graphics_enable_i;
	endproperty
	a_ext_write: assert property (p_ext_write) else $error("bad external write");
	property p_lower_disable;
		@(posedge clk_i) disable iff (rst_i)
			!strobes_o.external_read_out_n |-> cpu_addr_i <= cpu_glue_pkg::LOWER_16K_TOP;
	endproperty
	a_lower_disable: assert property (p_lower_disable) else $error("disable outside 16K");
	property p_io_out;
		@(posedge clk_i) disable iff (rst_i)
			(!cpu_ctl_i.iorq_n && !cpu_ctl_i.wr_n && ext_busrq_n_i) |-> !strobes_o.io_output_strobe_n;
	endproperty
	a_io_out: assert property (p_io_out) else $error("io output strobe missing");
	property p_cas_refresh;
		@(posedge clk_i) disable iff (rst_i) !cpu_ctl_i.refresh_cycle_n_n |-> column_strobe_n_o;
	endproperty
	a_cas_refresh: assert property (p_cas_refresh) else $error("column strobe in refresh");
	property p_region;
		@(posedge clk_i) disable iff (rst_i)
			(!cpu_ctl_i.mreq_n && !cpu_addr_i[15]) |-> !region_select_n_o[cpu_addr_i[14:12]];
	endproperty
	a_region: assert property (p_region) else $error("region not selected");
endmodule : cpu_clock_wait_bus_control

// File: shared/cpu_glue_pkg.sv
package cpu_glue_pkg;
	localparam int OSC_HZ = 16000000;
	localparam int CLK_HZ = 10000000;
	// Divider presets; the counter reloads after its last state for the current speed.
	localparam logic [3:0] PRESET_LOW = 4'h4;
	localparam logic [3:0] PRESET_HIGH = 4'h3;
	localparam logic [3:0] DIV_LAST_LOW = 4'hC;
	localparam logic [3:0] DIV_LAST_HIGH = 4'h6;
	localparam logic [3:0] HALF_LOW = 4'h8;
	localparam logic [3:0] HALF_HIGH = 4'h4;
	localparam int ONESHOT_CYCLES = 1000;
	localparam logic [15:0] FLOPPY_ADDR = 16'h37EC;
	localparam logic [15:0] IRQ_VECTOR = 16'h0038;
	localparam logic [15:0] LOWER_16K_TOP = 16'h3FFF;
	localparam logic [15:0] VIDEO_BASE = 16'h3C00;
	localparam logic [15:0] ROM_TOP = 16'h2FFF;
	localparam int REFRESH_BITS = 7;
	localparam logic [1:0] VIDEO_READ_WAITS = 2'h2;
	localparam logic [1:0] VIDEO_WRITE_WAITS = 2'h1;
	localparam logic [1:0] ROM_WAITS = 2'h1;

	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic mreq_n;
		logic iorq_n;
		logic m1_n;
		logic refresh_cycle_n_n;
	} cpu_ctl_t;

	typedef struct packed {
		logic internal_mem_read_n;
		logic internal_mem_write_n;
		logic external_read_out_n;
		logic external_write_out_n;
		logic io_output_strobe_n;
		logic io_input_strobe_n;
	} sys_strobe_t;
endpackage : cpu_glue_pkg

// File: verif/cpu_core_model.sv
`timescale 1ns/1ns
// Processor core stand-in: turns an operation code into control strobes.
module cpu_core_model (
	// Requested operation.
	input wire logic [2:0] op_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic busrq_n_i,
	// Processor pins.
	output logic [15:0] cpu_addr_o,
	output cpu_glue_pkg::cpu_ctl_t cpu_ctl_o,
	output logic [7:0] cpu_data_o
);
	always_comb begin
		cpu_addr_o = addr_i;
		// Undriven data shows the inverse so a stale value never passes.
		cpu_data_o = (op_i == 3'h2 || op_i == 3'h4) ? wdata_i : ~wdata_i;
		case (op_i)
			3'h1: cpu_ctl_o = 6'h17;
			3'h2: cpu_ctl_o = 6'h27;
			3'h3: cpu_ctl_o = 6'h1B;
			3'h4: cpu_ctl_o = 6'h2B;
			3'h5: cpu_ctl_o = 6'h36;
			default: cpu_ctl_o = 6'h3F;
		endcase
		// A master holding the bus still runs refresh cycles of its own.
		if (!busrq_n_i && op_i != 3'h5) begin
			cpu_ctl_o = 6'h3F;
			cpu_addr_o = ~addr_i;
		end
	end
endmodule : cpu_core_model

// File: verif/tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
	logic clk = 1'b0, rst = 1'b1, spd = 1'b1, aut = 1'b0, gfx = 1'b0;
	logic ewt = 1'b1, eint = 1'b1, ebrq = 1'b1;
	logic [2:0] op = 3'h0;
	logic [15:0] a = 16'h0, ca, sa;
	logic [7:0] wd = 8'h0, sdi = 8'h0, cdi, cdo, sdo, reg_n;
	cpu_glue_pkg::cpu_ctl_t c;
	cpu_glue_pkg::sys_strobe_t stb;
	logic cclk, rise, hs_n, fl_n, wt_n, int_n, brq_n, aoe, doe, coe, dir, bmr, mux, cas, rom;
	logic [22:0] q[$];
	int num_errors = 0, tests_run = 0, seed = 83, n, k;
	always #50 clk = ~clk;
	cpu_core_model i_cpu (.op_i(op), .addr_i(a), .wdata_i(wd), .busrq_n_i(brq_n),
		.cpu_addr_o(ca), .cpu_ctl_o(c), .cpu_data_o(cdi));
	cpu_clock_wait_bus_control #(.ONESHOT_LEN(20)) i_dut (
		.clk_i(clk), .rst_i(rst), .speed_select_switch_i(spd), .auto_speed_switch_i(aut),
		.cpu_clk_o(cclk), .cpu_clk_rise_o(rise), .high_speed_active_n_o(hs_n),
		.force_low_speed_n_o(fl_n), .cpu_addr_i(ca), .cpu_ctl_i(c), .cpu_data_i(cdi),
		.cpu_data_o(cdo), .cpu_wait_n_o(wt_n), .cpu_int_n_o(int_n), .cpu_busrq_n_o(brq_n),
		.sys_data_i(sdi), .sys_addr_o(sa), .sys_data_o(sdo), .sys_addr_oe_n_o(aoe),
		.sys_data_oe_n_o(doe), .sys_ctl_oe_n_o(coe), .data_in_direction_o(dir),
		.strobes_o(stb), .buffered_mem_request_n_o(bmr), .addr_mux_o(mux),
		.column_strobe_n_o(cas), .region_select_n_o(reg_n), .rom_read_n_o(rom),
		.graphics_enable_i(gfx), .ext_wait_n_i(ewt), .ext_int_n_i(eint),
		.ext_busrq_n_i(ebrq));
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	// Cycles between two processor clock reloads, sampled away from the edge.
	task automatic period(output int p);
		p = 0;
		@(negedge clk);
		while (rise !== 1'b1) @(negedge clk);
		do begin @(negedge clk); p++; end while (rise !== 1'b1);
	endtask : period
	// Counts cycles of processor wait while one access is held.
	task automatic waits(input logic [2:0] o, input logic [15:0] ad, output int w);
		w = 0;
		op = o;
		a = ad;
		repeat (8) begin @(negedge clk); if (wt_n === 1'b0) w++; end
		op = 3'h0;
		repeat (4) @(negedge clk);
	endtask : waits
	always @(posedge clk) begin
		if (q.size() > 0) begin
			logic [22:0] e;
			e = q.pop_front();
			`CHK("strobes", e[21:16], stb)
			`CHK("region", e[15:8], reg_n)
			`CHK("misc", e[7:0], {rom, dir, bmr, int_n, brq_n, aoe, doe, coe})
			if (!e[22]) `CHK("wait", 1'b0, wt_n)
		end
	end
	initial begin
		#2000000;
		num_errors++;
		conclude();
	end
	initial begin
		logic lmd, g;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		period(n);
		`CHK("fast", 8'h4, n[7:0])
		`CHK("hs_n", 1'b0, hs_n)
		@(negedge clk);
		`CHK("clk high", 1'b1, cclk)
		repeat (2) @(negedge clk);
		`CHK("clk low", 1'b0, cclk)
		$display("test fast done");
		spd = 1'b0;
		repeat (20) @(negedge clk);
		period(n);
		`CHK("slow", 8'h9, n[7:0])
		`CHK("fl_n", 1'b0, fl_n)
		spd = 1'b1;
		repeat (20) @(negedge clk);
		$display("test force done");
		waits(3'h1, 16'h0100, n);
		`CHK("rom wait", 1'b1, n > 0 && n <= 4)
		waits(3'h1, 16'h4000, k);
		`CHK("ram wait", 8'h0, k[7:0])
		waits(3'h1, 16'h3C00, k);
		`CHK("video wait", 1'b1, k > 4 && k <= 8)
		waits(3'h2, 16'h3C00, k);
		`CHK("video write wait", 1'b1, k > 0 && k <= 4)
		$display("test wait done");
		aut = 1'b1;
		op = 3'h2;
		a = cpu_glue_pkg::FLOPPY_ADDR;
		repeat (2) @(negedge clk);
		op = 3'h0;
		repeat (2) @(negedge clk);
		period(n);
		`CHK("auto slow", 8'h9, n[7:0])
		repeat (40) @(negedge clk);
		period(n);
		`CHK("auto fast", 8'h4, n[7:0])
		$display("test auto done");
		op = 3'h5;
		a = 16'h1234;
		repeat (3) @(negedge clk);
		`CHK("cas", 1'b1, cas)
		`CHK("mux", 1'b0, mux)
		`CHK("refresh", 7'h34, sa[6:0])
		op = 3'h0;
		a = 16'h4000;
		@(negedge clk);
		op = 3'h2;
		a = 16'h4000;
		wd = 8'hA5;
		repeat (2) @(negedge clk);
		`CHK("data out", 8'hA5, sdo)
		op = 3'h1;
		sdi = 8'h3C;
		repeat (2) @(negedge clk);
		`CHK("data in", 8'h3C, cdo)
		`CHK("upper", 8'h40, sa[15:8])
		$display("test bus done");
		// Random mix; the wait line is judged only where the bus pulls it.
		repeat (300) begin
			@(negedge clk);
			op = 3'($unsigned($random(seed)) % 6);
			a = 16'($random(seed));
			gfx = 1'($random(seed));
			ewt = 1'($random(seed));
			eint = 1'($random(seed));
			ebrq = ($unsigned($random(seed)) % 6) != 0;
			#1;
			g = c.mreq_n | a[15];
			lmd = gfx && (a <= cpu_glue_pkg::LOWER_16K_TOP);
			q.push_back({ewt, c.rd_n | c.mreq_n, c.wr_n | c.mreq_n,
				c.rd_n | c.mreq_n | !lmd, c.wr_n | c.mreq_n | !lmd,
				c.wr_n | c.iorq_n, c.rd_n | c.iorq_n,
				g ? 8'hFF : ~(8'h01 << a[14:12]),
				c.rd_n | c.mreq_n | (a > cpu_glue_pkg::ROM_TOP), !c.rd_n, c.mreq_n,
				eint, ebrq, {3{!ebrq}}});
		end
		@(negedge clk);
		$display("test random done");
		conclude();
	end
endmodule : tb_top
